// ===== core/mft_params.svh
// Purpose: constants of the frame transfer config link and registers
// Assumes: included by its bare name
// Notes: definitions only
`ifndef MFT_PARAMS_SVH
`define MFT_PARAMS_SVH
// device register addresses and filter address high bits (7-bit link address space)
`define MFT_CFG_ADDR 7'h04
`define MFT_CAP_ADDR 7'h02
`define MFT_CFG2_ADDR 7'h06
`define MFT_FILT_HI 3'h5
// config field positions
`define MFT_SYNC 15
`define MFT_TXCT 9
`define MFT_RXCT 8
`define MFT_TSE 7
`define MFT_TSS 6
`define MFT_PROT 5
`define MFT_CHUNK_SEQ_RETRY_EN 4
`define MFT_FWD 2
// chunk payload selector codes
`define MFT_CPS_RST 3'h6
`define MFT_CPS_MIN 3'h3
`define MFT_CPS_MAX 3'h6
// frame lengths in link bits
`define MFT_CMD_BITS 7'h08
`define MFT_LEN_PLAIN 7'h28
`define MFT_LEN_CRC 7'h30
`define MFT_LEN_COMP 7'h48
// link clock: clk period and half period of the host divider
`define MFT_CLK_NS 4
`define MFT_SCLK_HALF_NS 40
`define MFT_SCLK_HALF (`MFT_SCLK_HALF_NS / `MFT_CLK_NS)
// crc8 polynomial
`define MFT_CRC_POLY 8'h07
// host avalon byte offsets
`define MFT_AV_CMD 5'h00
`define MFT_AV_WDATA 5'h04
`define MFT_AV_RDATA 5'h08
`define MFT_AV_STATUS 5'h0c
`define MFT_AV_MODE 5'h10
`endif

// ===== core/mft_pkg.sv
// Purpose: types and frame helpers shared by both link ends
// Assumes: mft_params.svh for constants
// Notes: frames travel msb first
`default_nettype none
`include "mft_params.svh"
package mft_pkg;
  typedef logic [31:0] mft_word_type;
  typedef logic [63:0] mft_frame_type;
  typedef enum logic [1:0] {MFT_H_IDLE, MFT_H_LOW, MFT_H_HIGH, MFT_H_TAIL} mft_hstate_type;

  // serial crc8 over one word
  function automatic logic [7:0] mft_crc8(input mft_word_type d);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
    begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0};
      if (fb)
        c = c ^ `MFT_CRC_POLY;
    end
    return c;
  endfunction

  // total link bits of one frame
  function automatic logic [6:0] mft_frame_len(input logic prot, input logic gen);
    if (!prot)
      return `MFT_LEN_PLAIN;
    else if (gen)
      return `MFT_LEN_CRC;
    return `MFT_LEN_COMP;
  endfunction

  // data word plus protection, left aligned
  function automatic mft_frame_type mft_pack(input mft_word_type d, input logic prot,
                                             input logic gen);
    if (!prot)
      return {d, 32'h0};
    else if (gen)
      return {d, mft_crc8(d), 24'h0};
    return {d, ~d};
  endfunction

  // data word out of the received bits, right aligned
  function automatic mft_word_type mft_unpack(input mft_frame_type s, input logic prot,
                                              input logic gen);
    if (!prot)
      return s[31:0];
    else if (gen)
      return s[39:8];
    return s[63:32];
  endfunction

  // protection check of the received bits
  function automatic logic mft_check(input mft_frame_type s, input logic prot,
                                     input logic gen);
    if (!prot)
      return 1'b1;
    else if (gen)
      return s[7:0] == mft_crc8(s[39:8]);
    return s[31:0] == ~s[63:32];
  endfunction
endpackage
`default_nettype wire

// ===== core/mft_link_if.sv
// Purpose: serial control link between host and device
// Assumes: host makes sclk, cs_n active low
// Notes: no clocking block; each end syncs what it receives
`timescale 1ns/1ps
`default_nettype none
interface mft_link_if;
  logic sclk; // link clock from host
  logic cs_n; // frame select, active low
  logic mosi; // host to device
  logic miso; // device to host
  modport dev (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface
`default_nettype wire

// ===== core/mft_device.sv
// Purpose: device end, frame transfer configuration register bank
// Assumes: link pins are asynchronous; straps are pins
// Notes: frame = 8 cmd bits {write, addr[6:0]}, 32 data bits, protection
//
// Summary of operation
// R01: tx cut-through launches frames before full buffering
// R02: host feeds transmit data above 10 Mbps
// R03: rx cut-through delivers before frame completes
// R04: host enables rx cut-through before reception
// R05: host keeps rx cut-through zero in generic
// R06: timestamp enable gates both directions
// R07: size select picks 32 or 64 bit
// R08: chunk protocol protection sends word complements
// R09: generic protocol protection appends crc8
// R10: protection bit read-only, from power-up strap
// R11: sequence retry unsupported, flag ignored
// R12: payload selector gives 2^n bytes, 8..64
// R13: host sets payload size before traffic
// R14: host never changes size mid frame
// R15: payload size frozen once synced
// R16: capability register reports minimum chunk size
// R17: sync bit sets by writing one only
// R18: host avoids unlisted payload selector codes
`timescale 1ns/1ps
`default_nettype none
`include "mft_params.svh"
module mft_device (
  // system
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // link
  mft_link_if.dev link,
  // straps
  input wire logic ctrl_protect_strap,
  input wire logic spi_generic_strap,
  // datapath status
  input wire logic tx_bytes_ready,
  input wire logic tx_frame_whole,
  input wire logic rx_bytes_ready,
  input wire logic rx_frame_whole,
  // configuration out
  output logic tx_cut_through_en,
  output logic rx_cut_through_en,
  output logic timestamp_en,
  output logic timestamp_64,
  output logic ctrl_protect_en,
  output logic spi_generic,
  output logic config_synced,
  output logic [6:0] chunk_payload_bytes,
  // datapath control out
  output logic tx_launch,
  output logic rx_deliver,
  output logic link_error
);
  import mft_pkg::*;

  // synchroniser stages; stage one feeds only stage two
  logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, mosi_s1, mosi_s2; // link pins
  logic prot_s1, prot_s2, gen_s1, gen_s2; // strap pins
  logic [1:0] strap_wait; // settle time before straps are taken
  logic strap_taken; // straps caught once
  // frame state
  logic [6:0] cnt; // bits taken in this frame
  logic [7:0] cmd; // write flag and address
  mft_frame_type sh; // data and protection bits
  mft_frame_type out_sh; // read answer, msb first
  logic miso; // registered link output
  // stored configuration
  logic timestamp_size_sel; // 0: 32 bit, 1: 64 bit
  logic chunk_seq_retry_en; // stored, no effect
  logic [2:0] chunk_payload_sel; // n of 2^n bytes
  // combinational helpers
  logic sclk_rise, sclk_fall;
  logic [7:0] next_cmd;
  mft_frame_type next_sh;
  logic [6:0] frame_len;
  logic bit_take, frame_end, wr_ok, wr_cfg;
  mft_word_type wr_data, rd_word, cfg_word;

  assign link.miso = miso;

  // link and strap pins: two flops before use, third sclk flop for edge detection
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      prot_s1 <= 1'b0;
      prot_s2 <= 1'b0;
      gen_s1 <= 1'b0;
      gen_s2 <= 1'b0;
    end
    else if (ce)
    begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
      mosi_s1 <= link.mosi;
      mosi_s2 <= mosi_s1;
      prot_s1 <= ctrl_protect_strap;
      prot_s2 <= prot_s1;
      gen_s1 <= spi_generic_strap;
      gen_s2 <= gen_s1;
    end
  end

  // straps caught once after release; reset itself takes only constants
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      ctrl_protect_en <= 1'b0;
      spi_generic <= 1'b0;
    end
    else if (ce)
    begin
      if (strap_wait != 2'h3)
        strap_wait <= strap_wait + 2'h1;
      else if (!strap_taken)
      begin
        strap_taken <= 1'b1;
        ctrl_protect_en <= prot_s2; // [R10]
        spi_generic <= gen_s2;
      end
    end
  end

  // edge and frame decode
  always_comb
  begin
    sclk_rise = sclk_s2 & ~sclk_s3;
    sclk_fall = ~sclk_s2 & sclk_s3;
    next_cmd = {cmd[6:0], mosi_s2};
    next_sh = {sh[62:0], mosi_s2};
    frame_len = mft_frame_len(ctrl_protect_en, spi_generic);
    bit_take = sclk_rise & ~cs_s2 & (cnt < frame_len);
    frame_end = bit_take & (cnt == frame_len - 7'h01);
    // complement under chunk protocol, crc8 under generic
    wr_ok = mft_check(next_sh, ctrl_protect_en, spi_generic); // [R08] [R09]
    wr_data = mft_unpack(next_sh, ctrl_protect_en, spi_generic);
    wr_cfg = frame_end & cmd[7] & wr_ok & (cmd[6:0] == `MFT_CFG_ADDR);
  end

  // read view; bits outside this bank read as zero
  always_comb
  begin
    cfg_word = 32'h0;
    cfg_word[`MFT_SYNC] = config_synced;
    cfg_word[`MFT_TXCT] = tx_cut_through_en;
    cfg_word[`MFT_RXCT] = rx_cut_through_en;
    cfg_word[`MFT_TSE] = timestamp_en;
    cfg_word[`MFT_TSS] = timestamp_size_sel;
    cfg_word[`MFT_PROT] = ctrl_protect_en;
    cfg_word[`MFT_CHUNK_SEQ_RETRY_EN] = chunk_seq_retry_en;
    cfg_word[2:0] = chunk_payload_sel;
    case (next_cmd[6:0])
      `MFT_CFG_ADDR: rd_word = cfg_word;
      // minimum size code; bit 3 zero: no sequence retry
      `MFT_CAP_ADDR: rd_word = {29'h0, `MFT_CPS_MIN}; // [R16] [R11]
      default: rd_word = 32'h0;
    endcase
  end

  // receive bits; aborted frames are dropped when cs_n rises
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= 7'h00;
      cmd <= 8'h00;
      sh <= 64'h0;
    end
    else if (ce)
    begin
      if (cs_s2)
        cnt <= 7'h00;
      else if (bit_take)
      begin
        cnt <= cnt + 7'h01;
        if (cnt < `MFT_CMD_BITS)
          cmd <= next_cmd;
        else
          sh <= next_sh;
      end
    end
  end

  // read answer loaded at the last command bit, shifted on falling edges
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_sh <= 64'h0;
      miso <= 1'b0;
    end
    else if (ce)
    begin
      if (cs_s2)
        miso <= 1'b0;
      else if (bit_take & (cnt == `MFT_CMD_BITS - 7'h01) & ~next_cmd[7])
        out_sh <= mft_pack(rd_word, ctrl_protect_en, spi_generic); // [R08] [R09]
      else if (sclk_fall & (cnt >= `MFT_CMD_BITS))
      begin
        miso <= out_sh[63];
        out_sh <= {out_sh[62:0], 1'b0};
      end
    end
  end

  // writable configuration bits, sync flag and payload selector
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_cut_through_en <= 1'b0;
      rx_cut_through_en <= 1'b0;
      timestamp_en <= 1'b0;
      timestamp_size_sel <= 1'b0;
      chunk_seq_retry_en <= 1'b0;
      config_synced <= 1'b0;
      chunk_payload_sel <= `MFT_CPS_RST; // [R12]
    end
    else if (ce && wr_cfg)
    begin
      tx_cut_through_en <= wr_data[`MFT_TXCT];
      rx_cut_through_en <= wr_data[`MFT_RXCT];
      timestamp_en <= wr_data[`MFT_TSE];
      timestamp_size_sel <= wr_data[`MFT_TSS];
      // stored for readback only; the header sequence flag is never looked at
      chunk_seq_retry_en <= wr_data[`MFT_CHUNK_SEQ_RETRY_EN]; // [R11]
      // sync only ever sets; selector frozen once synced, unlisted codes kept
      config_synced <= config_synced | wr_data[`MFT_SYNC]; // [R17]
      if (!config_synced && wr_data[2:0] inside {[`MFT_CPS_MIN:`MFT_CPS_MAX]}) // [R15]
        chunk_payload_sel <= wr_data[2:0]; // [R12]
    end
  end

  // derived controls for the datapath; bad protection drops the write, pulses error
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chunk_payload_bytes <= 7'h40;
      timestamp_64 <= 1'b0;
      tx_launch <= 1'b0;
      rx_deliver <= 1'b0;
      link_error <= 1'b0;
    end
    else if (ce)
    begin
      chunk_payload_bytes <= 7'h01 << chunk_payload_sel; // [R12]
      // size matters only while stamping is on, for rx and tx alike
      timestamp_64 <= timestamp_en & timestamp_size_sel; // [R06] [R07]
      // cut-through starts on the first bytes, else waits for the whole frame
      tx_launch <= tx_cut_through_en ? tx_bytes_ready : tx_frame_whole; // [R01]
      rx_deliver <= rx_cut_through_en ? rx_bytes_ready : rx_frame_whole; // [R03]
      link_error <= frame_end & cmd[7] & ~wr_ok; // [R08] [R09]
    end
  end
endmodule // mft_device
`default_nettype wire

// ===== core/mft_host.sv
// Purpose: host end, issues register frames ordered over Avalon-MM
// Assumes: frame_active comes from logic on clk
// Notes: refuses config writes that break the ordering the device needs
`timescale 1ns/1ps
`default_nettype none
`include "mft_params.svh"
module mft_host (
  // system
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  // link
  mft_link_if.host link,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire mft_pkg::mft_word_type avs_writedata,
  output mft_pkg::mft_word_type avs_readdata,
  output logic avs_waitrequest,
  // user status
  input wire logic frame_active
);
  import mft_pkg::*;

  mft_hstate_type state; // frame engine
  logic [3:0] div; // half period counter
  logic [6:0] bitcnt; // bits sent
  logic [6:0] len; // length of this frame
  logic [71:0] tx_sh; // cmd and data, msb first
  mft_frame_type rx_sh; // bits after the command
  logic sclk, cs_n; // registered link outputs
  logic miso_s1, miso_s2; // miso synchroniser
  logic [7:0] cmd; // command in flight
  mft_word_type wdata, rdata, cfg_sh; // write data, read data, config shadow
  logic busy, st_done, st_err, st_refused;
  logic mode_prot, mode_gen; // protocol mode of the device
  logic opened; // traffic or reception already enabled
  logic rd_ack; // one wait cycle for reads
  // combinational helpers
  logic cmd_wr, half_end, refuse, sclk_go, done_set, err_set;
  mft_word_type send;

  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.mosi = tx_sh[71];
  // command writes stall while a frame runs; reads wait one cycle
  assign avs_waitrequest = (avs_read & ~rd_ack)
                         | (avs_write & (avs_address == `MFT_AV_CMD) & busy);

  // order checks on a config write
  always_comb
  begin
    cmd_wr = avs_write & (avs_address == `MFT_AV_CMD) & ~busy;
    half_end = div == 4'(`MFT_SCLK_HALF - 1);
    send = wdata;
    // generic protocol never carries rx cut-through
    if (mode_gen)
      send[`MFT_RXCT] = 1'b0; // [R05]
    refuse = 1'b0;
    if (avs_writedata[8] && avs_writedata[6:0] == `MFT_CFG_ADDR)
    begin
      if (send[2:0] < `MFT_CPS_MIN || send[2:0] > `MFT_CPS_MAX)
        refuse = 1'b1; // [R18]
      if (send[2:0] != cfg_sh[2:0] && (opened || frame_active || cfg_sh[`MFT_SYNC]))
        refuse = 1'b1; // [R13] [R14]
      if (send[`MFT_RXCT] != cfg_sh[`MFT_RXCT] && opened)
        refuse = 1'b1; // [R04]
    end
    sclk_go = cmd_wr & ~refuse;
    done_set = (state == MFT_H_TAIL) & half_end;
    err_set = done_set & ~cmd[7] & ~mft_check(rx_sh, mode_prot, mode_gen); // [R08] [R09]
  end

  // miso from the device passes two flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end
    else if (ce)
    begin
      miso_s1 <= link.miso;
      miso_s2 <= miso_s1;
    end
  end

  // frame engine; sclk divided from clk keeps the link above 10 Mbps
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= MFT_H_IDLE;
      div <= 4'h0;
      bitcnt <= 7'h00;
      len <= 7'h00;
      tx_sh <= 72'h0;
      rx_sh <= 64'h0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      cmd <= 8'h00;
      busy <= 1'b0;
    end
    else if (ce)
    begin
      div <= (state == MFT_H_IDLE || half_end) ? 4'h0 : div + 4'h1; // [R02]
      case (state)
        MFT_H_IDLE:
          if (sclk_go)
          begin
            cmd <= {avs_writedata[8], avs_writedata[6:0]};
            len <= mft_frame_len(mode_prot, mode_gen);
            // protected writes carry complement or crc8, reads leave data bits zero
            tx_sh <= {avs_writedata[8], avs_writedata[6:0],
                      avs_writedata[8] ? mft_pack(send, mode_prot, mode_gen) : 64'h0};
            bitcnt <= 7'h00;
            cs_n <= 1'b0;
            busy <= 1'b1;
            state <= MFT_H_LOW;
          end
        MFT_H_LOW:
          if (half_end)
          begin
            if (bitcnt >= `MFT_CMD_BITS)
              rx_sh <= {rx_sh[62:0], miso_s2};
            sclk <= 1'b1;
            state <= MFT_H_HIGH;
          end
        MFT_H_HIGH:
          if (half_end)
          begin
            sclk <= 1'b0;
            bitcnt <= bitcnt + 7'h01;
            tx_sh <= {tx_sh[70:0], 1'b0};
            state <= (bitcnt == len - 7'h01) ? MFT_H_TAIL : MFT_H_LOW;
          end
        MFT_H_TAIL:
          if (half_end)
          begin
            cs_n <= 1'b1;
            busy <= 1'b0;
            state <= MFT_H_IDLE;
          end
        default:
          state <= MFT_H_IDLE;
      endcase
    end
  end

  // software registers; status flags clear by writing one, set wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wdata <= 32'h0;
      rdata <= 32'h0;
      cfg_sh <= {29'h0, `MFT_CPS_RST};
      st_done <= 1'b0;
      st_err <= 1'b0;
      st_refused <= 1'b0;
      mode_prot <= 1'b0;
      mode_gen <= 1'b0;
      opened <= 1'b0;
    end
    else if (ce)
    begin
      if (avs_write && avs_address == `MFT_AV_WDATA)
        wdata <= avs_writedata;
      if (avs_write && avs_address == `MFT_AV_MODE)
      begin
        mode_prot <= avs_writedata[0];
        mode_gen <= avs_writedata[1];
      end
      // forwarding unknown frames or any filter write opens reception
      if (frame_active || (sclk_go && avs_writedata[8]
          && ((avs_writedata[6:0] == `MFT_CFG2_ADDR && wdata[`MFT_FWD])
          || avs_writedata[6:4] == `MFT_FILT_HI)))
        opened <= 1'b1; // [R04]
      if (done_set && !cmd[7])
        rdata <= mft_unpack(rx_sh, mode_prot, mode_gen);
      if (done_set && !cmd[7] && cmd[6:0] == `MFT_CFG_ADDR && !err_set)
        cfg_sh <= mft_unpack(rx_sh, mode_prot, mode_gen);
      else if (sclk_go && avs_writedata[8] && avs_writedata[6:0] == `MFT_CFG_ADDR)
        cfg_sh <= send | {16'h0, cfg_sh[`MFT_SYNC], 15'h0}; // [R17]
      st_done <= done_set | (st_done & ~(avs_write && avs_address == `MFT_AV_STATUS
                 && avs_writedata[1]));
      st_err <= err_set | (st_err & ~(avs_write && avs_address == `MFT_AV_STATUS
                && avs_writedata[2]));
      st_refused <= (cmd_wr & refuse) | (st_refused & ~(avs_write
                    && avs_address == `MFT_AV_STATUS && avs_writedata[3]));
    end
  end

  // registered read data after one wait cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_ack <= 1'b0;
      avs_readdata <= 32'h0;
    end
    else if (ce)
    begin
      rd_ack <= avs_read & ~rd_ack;
      if (avs_read && !rd_ack)
        case (avs_address)
          `MFT_AV_CMD: avs_readdata <= {24'h0, cmd};
          `MFT_AV_WDATA: avs_readdata <= wdata;
          `MFT_AV_RDATA: avs_readdata <= rdata;
          `MFT_AV_STATUS: avs_readdata <= {28'h0, st_refused, st_err, st_done, busy};
          `MFT_AV_MODE: avs_readdata <= {30'h0, mode_gen, mode_prot};
          default: avs_readdata <= 32'h0;
        endcase
    end
  end
endmodule // mft_host
`default_nettype wire

// ===== verification/mft_link_props.sv
// Purpose: link pin checks between host and device ends
// Assumes: host half period of ten clk cycles
// Notes: watches the link wires only
`timescale 1ns/1ps
`default_nettype none
module mft_link_props (
  // system
  input wire logic clk,
  input wire logic reset_n,
  // link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // lead-in before the first rise
  sequence s_low_run;
    !sclk [*8];
  endsequence
  // one high phase, ten cycles exactly
  sequence s_high_ten;
    sclk [*8] ##1 sclk ##1 sclk ##1 !sclk;
  endsequence
  // device sees cs_n late, so allow its sync delay
  property p_miso_idle;
    cs_n [*5] |-> !miso;
  endproperty
  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  property p_sclk_hold;
    $changed(sclk) |=> $stable(sclk) [*8];
  endproperty
  property p_mosi_hold;
    sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  property p_cs_lead;
    $fell(cs_n) |-> s_low_run;
  endproperty
  property p_miso_shift;
    !cs_n && $changed(miso) |-> !sclk;
  endproperty
  property p_cs_end;
    $rose(cs_n) |-> !sclk ##1 cs_n [*4];
  endproperty
  property p_high_len;
    $rose(sclk) |-> s_high_ten;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso not idle");
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk not idle");
  a_sclk_hold: assert property (p_sclk_hold) else $error("sclk phase short");
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved");
  a_cs_lead: assert property (p_cs_lead) else $error("frame lead short");
  a_miso_shift: assert property (p_miso_shift) else $error("miso moved high");
  a_cs_end: assert property (p_cs_end) else $error("frame end bad");
  a_high_len: assert property (p_high_len) else $error("sclk high len");
endmodule // mft_link_props
`default_nettype wire

// ===== verification/test_macphy_frame_transfer_config.sv
// Purpose: both link ends driven from the host avalon side
// Assumes: straps change only under reset
// Notes: one pass per protection mode: none, complement, crc8
`timescale 1ns/1ps
`default_nettype none
`include "mft_params.svh"
module test_macphy_frame_transfer_config;
  import mft_pkg::*;
  // compare and count
  `define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
  logic clk, reset_n, pstrap, gstrap, txr, rxr, txw, rxw, fact, p, g, lerr;
  logic lerr_hit = 1'b0; // sticky: any link error pulse seen
  logic ct_tx, ct_rx, ts_en, ts_64, prot, gen, synced, launch, deliver;
  logic [6:0] bytes;
  logic [4:0] address;
  logic rd, wr, wait_req;
  logic [3:0] st;
  mft_word_type wdata, rdata, rq, r;
  int err_count, total_checks, cyc;
  mft_link_if link();
  mft_device u_mft_device (.clk(clk), .reset_n(reset_n), .ce(1'b1), .link(link),
    .ctrl_protect_strap(pstrap), .spi_generic_strap(gstrap), .tx_bytes_ready(txr),
    .tx_frame_whole(txw), .rx_bytes_ready(rxr), .rx_frame_whole(rxw),
    .tx_cut_through_en(ct_tx), .rx_cut_through_en(ct_rx), .timestamp_en(ts_en),
    .timestamp_64(ts_64), .ctrl_protect_en(prot), .spi_generic(gen),
    .config_synced(synced), .chunk_payload_bytes(bytes), .tx_launch(launch),
    .rx_deliver(deliver), .link_error(lerr));
  mft_host u_mft_host (.clk(clk), .reset_n(reset_n), .ce(1'b1), .link(link),
    .avs_address(address), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(wait_req), .frame_active(fact));
  mft_link_props u_mft_link_props (.clk(clk), .reset_n(reset_n), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard, well above three passes
  always @(posedge clk)
  begin
    cyc++;
    if (lerr === 1'b1)
      lerr_hit <= 1'b1;
    if (cyc == 60000)
    begin
      err_count++;
      results();
    end
  end
  task results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is low
  task av(input logic w, input logic [4:0] a, input mft_word_type d);
    address <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do @(posedge clk); while (wait_req !== 1'b0);
    rq = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // one link frame; status kept, then cleared
  task frame(input logic w, input logic [6:0] a, input mft_word_type d);
    av(1'b1, `MFT_AV_WDATA, d);
    av(1'b1, `MFT_AV_CMD, {23'h0, w, 1'b0, a});
    do av(1'b0, `MFT_AV_STATUS, 32'h0); while (rq[0] === 1'b1);
    st = rq[3:0];
    av(1'b1, `MFT_AV_STATUS, 32'he);
    if (!w)
      av(1'b0, `MFT_AV_RDATA, 32'h0);
  endtask
  // reset with straps, then defaults
  task t_reset;
    reset_n <= 1'b0;
    pstrap <= p;
    gstrap <= g;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("bytes", 7'h40, bytes)
    `CHK("prot", p, prot)
    `CHK("sync", 1'b0, synced)
    `CHK("gen", g, gen)
    av(1'b1, `MFT_AV_MODE, {30'h0, g, p});
  endtask
  // full config write; protect bit written but strap wins
  task t_config;
    frame(1'b1, 7'h04, 32'h3f3);
    `CHK("st", 4'h2, st)
    `CHK("txct", 1'b1, ct_tx)
    `CHK("rxct", ~g, ct_rx)
    `CHK("ts64", 1'b1, ts_64)
    `CHK("tsen", 1'b1, ts_en)
    `CHK("prot", p, prot)
    `CHK("bytes", 7'h08, bytes)
  endtask
  // read answers of config and capability, protected in the complement and crc8 passes
  task t_readback;
    frame(1'b0, 7'h04, 32'h0);
    `CHK("st", 4'h2, st)
    `CHK("cfg", 32'h2d3 | {23'h0, ~g, 8'h0} | {26'h0, p, 5'h0}, rq)
    frame(1'b0, 7'h02, 32'h0);
    `CHK("cap", 32'h3, rq)
  endtask
  // tx data, and rx data outside generic, moves before whole frames are in
  task t_cut;
    txr <= 1'b1;
    rxr <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("launch", 1'b1, launch)
    `CHK("deliver", ~g, deliver)
    txr <= 1'b0;
    rxr <= 1'b0;
  endtask
  // unlisted code, then a change while a frame is busy
  task t_refuse;
    frame(1'b1, 7'h04, 32'h7);
    `CHK("st", 4'h8, st)
    fact <= 1'b1;
    frame(1'b1, 7'h04, 32'h5);
    `CHK("st", 4'h8, st)
    `CHK("bytes", 7'h08, bytes)
    // rx cut-through change once reception is open; generic always sends zero
    frame(1'b1, 7'h04, {23'h0, g, 8'h03});
    `CHK("st", g ? 4'h2 : 4'h8, st)
    fact <= 1'b0;
  endtask
  // sync sets, a zero write keeps it
  task t_sync;
    r = {23'h0, ~g, 8'h03};
    frame(1'b1, 7'h04, r | 32'h8000);
    `CHK("sync", 1'b1, synced)
    `CHK("tsen", 1'b0, ts_en)
    `CHK("ts64", 1'b0, ts_64)
    frame(1'b1, 7'h04, r);
    `CHK("sync", 1'b1, synced)
    `CHK("bytes", 7'h08, bytes)
    // tx cut-through now off: launch waits for the whole frame
    {txr, rxr, txw, rxw} <= 4'b1100;
    repeat (3) @(posedge clk);
    `CHK("launch", 1'b0, launch)
    `CHK("deliver", ~g, deliver)
    {txw, rxw} <= 2'b11;
    repeat (3) @(posedge clk);
    `CHK("launch", 1'b1, launch)
    `CHK("deliver", 1'b1, deliver)
    {txr, rxr, txw, rxw} <= 4'b0000;
    `CHK("lerr", 1'b0, lerr_hit)
  endtask
  // main sequence
  initial
  begin
    {reset_n, pstrap, gstrap, txr, rxr, fact, rd, wr, txw, rxw} = 10'h0;
    address = 5'h0;
    wdata = 32'h0;
    for (int m = 0; m < 3; m++)
    begin
      p = (m > 0);
      g = (m == 2);
      t_reset();
      t_config();
      t_readback();
      t_cut();
      t_refuse();
      t_sync();
    end
    results();
  end
endmodule // test_macphy_frame_transfer_config
`default_nettype wire
